/* File: design/ecc_regs.svh */
// Register map, field positions, reset values and mode codes of the unit.
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH

`define ECC_OFF_CTRL  8'h00
`define ECC_OFF_PIE   8'h04
`define ECC_OFF_PIR   8'h08
`define ECC_OFF_CCL   8'h0C
`define ECC_OFF_CCH   8'h10

`define ECC_CTRL_RST  8'h00
`define ECC_PIE_RST   8'h00
`define ECC_PIR_RST   8'h00
`define ECC_IRQ_MASK  8'h7B
`define ECC_FLAG_BIT  5

`define ECC_M_OFF     4'h0
`define ECC_M_TOG     4'h2
`define ECC_M_CFALL   4'h4
`define ECC_M_CRISE   4'h5
`define ECC_M_C4      4'h6
`define ECC_M_C16     4'h7
`define ECC_M_SET     4'h8
`define ECC_M_CLR     4'h9
`define ECC_M_SWI     4'hA
`define ECC_M_SPEC    4'hB

`define ECC_ST_SINGLE 2'h0
`define ECC_ST_FWD    2'h1
`define ECC_ST_HALF   2'h2
`define ECC_ST_REV    2'h3

`define ECC_PS4_LAST  4'h3
`define ECC_PS16_LAST 4'hF

`define ECC_RESP_OK   2'h0
`define ECC_RESP_ERR  2'h2

`endif

/* File: design/ecc_pkg.sv */
// Types shared by the capture/compare/PWM unit.
package ecc_pkg;

  typedef enum logic [1:0] {
    ecc_k_off  = 2'b00,
    ecc_k_capt = 2'b01,
    ecc_k_cmp  = 2'b10,
    ecc_k_pwm  = 2'b11
  } ecc_kind_e;

  typedef struct packed {
    logic [1:0] steer;
    logic [1:0] duty_lo;
    logic [3:0] mode;
  } ecc_ctrl_s;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ecc_pins_s;

endpackage

/* File: design/ecc_unit.sv */
// Capture/compare/PWM unit: mode control, capture path, compare actions, output steering.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_regs.svh"

module ecc_unit (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [7:0]         s_awaddr,
  input  wire logic               s_awvalid,
  output logic                    s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output logic                    s_wready,
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire logic               s_bready,
  input  wire logic [7:0]         s_araddr,
  input  wire logic               s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire logic               s_rready,
  input  wire logic               capture_pin_in,
  input  wire logic [15:0]        first_timer_count,
  input  wire logic               pwm_a_in,
  input  wire logic               pwm_b_in,
  input  wire logic               adc_enabled,
  output logic                    use_second_timer,
  output logic [9:0]              duty_value,
  output logic                    first_timer_reset,
  output logic                    adc_start,
  output ecc_pkg::ecc_pins_s      pin_out,
  output ecc_pkg::ecc_pins_s      pin_oe
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  function automatic ecc_pkg::ecc_kind_e kind_of(input logic [3:0] m);
    ecc_pkg::ecc_kind_e k;
    k = ecc_pkg::ecc_k_off;
    if (m[3:2] == 2'b11) begin
      k = ecc_pkg::ecc_k_pwm;
    end else if (m[3:2] == 2'b01) begin
      k = ecc_pkg::ecc_k_capt;
    end else if (m[3] || m == `ECC_M_TOG) begin
      k = ecc_pkg::ecc_k_cmp;
    end
    return k;
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] d,
                                         input logic [3:0]  s,
                                         input logic [7:0]  old);
    return s[0] ? d[7:0] : old;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************

  ecc_pkg::ecc_ctrl_s ctrl;
  logic [7:0]         pie;
  logic [7:0]         pir;
  logic [15:0]        ccv;
  logic               cmp_out;
  logic               sync1;
  logic               sync2;
  logic               pin_prev;
  logic [3:0]         ps_cnt;
  logic               match_q;

  logic               aw_got;
  logic               w_got;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;

  // ****************************************************************
  // Mode decode
  // ****************************************************************

  ecc_pkg::ecc_kind_e kind;
  wire                is_capt;
  wire                is_cmp;
  wire                is_pwm;
  wire                inv_ac;
  wire                inv_bd;

  // Reserved codes 0001 and 0011 decode as off.
  assign kind    = kind_of(ctrl.mode);
  assign is_capt = (kind == ecc_pkg::ecc_k_capt);
  assign is_cmp  = (kind == ecc_pkg::ecc_k_cmp);
  assign is_pwm  = (kind == ecc_pkg::ecc_k_pwm);
  assign inv_ac  = ctrl.mode[1];
  assign inv_bd  = ctrl.mode[0];

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  wire        wr_go;
  wire        ar_hs;
  wire        wr_ctrl;
  wire        wr_pie;
  wire        wr_pir;
  wire        wr_ccl;
  wire        wr_cch;
  wire        wr_hit;
  wire        rd_hit;
  wire [31:0] rd_word;

  assign wr_go   = aw_got && w_got && !s_bvalid;
  assign ar_hs   = s_arvalid && s_arready;
  assign wr_ctrl = wr_go && (awaddr_q == `ECC_OFF_CTRL);
  assign wr_pie  = wr_go && (awaddr_q == `ECC_OFF_PIE);
  assign wr_pir  = wr_go && (awaddr_q == `ECC_OFF_PIR);
  assign wr_ccl  = wr_go && (awaddr_q == `ECC_OFF_CCL);
  assign wr_cch  = wr_go && (awaddr_q == `ECC_OFF_CCH);
  assign wr_hit  = wr_ctrl || wr_pie || wr_pir || wr_ccl || wr_cch;

  assign rd_hit  = (s_araddr == `ECC_OFF_CTRL) || (s_araddr == `ECC_OFF_PIE) ||
                   (s_araddr == `ECC_OFF_PIR) || (s_araddr == `ECC_OFF_CCL) ||
                   (s_araddr == `ECC_OFF_CCH);
  assign rd_word = (s_araddr == `ECC_OFF_CTRL) ? {24'h000000, ctrl} :
                   (s_araddr == `ECC_OFF_PIE)  ? {24'h000000, pie} :
                   (s_araddr == `ECC_OFF_PIR)  ? {24'h000000, pir} :
                   (s_araddr == `ECC_OFF_CCL)  ? {24'h000000, ccv[7:0]} :
                   (s_araddr == `ECC_OFF_CCH)  ? {24'h000000, ccv[15:8]} :
                   32'h00000000;

  // ****************************************************************
  // Capture path
  // ****************************************************************

  wire rise;
  wire fall;
  wire capt_evt;

  // Edges are taken from the synchronised pin level, whatever drives it.
  assign rise = sync2 && !pin_prev;
  assign fall = !sync2 && pin_prev;

  assign capt_evt = is_capt && (
                    (ctrl.mode == `ECC_M_CFALL && fall) ||
                    (ctrl.mode == `ECC_M_CRISE && rise) ||
                    (ctrl.mode == `ECC_M_C4 && rise && ps_cnt[1:0] == `ECC_PS4_LAST) ||
                    (ctrl.mode == `ECC_M_C16 && rise && ps_cnt == `ECC_PS16_LAST));

  // ****************************************************************
  // Compare path
  // ****************************************************************

  wire match_now;
  wire match_evt;
  wire spec_evt;
  wire flag_evt;

  assign match_now = is_cmp && (first_timer_count == ccv);
  assign match_evt = match_now && !match_q;
  assign spec_evt  = match_evt && (ctrl.mode == `ECC_M_SPEC);
  assign flag_evt  = capt_evt || match_evt;

  // ****************************************************************
  // Next values
  // ****************************************************************

  logic [7:0]  next_pir;
  logic [15:0] next_ccv;
  logic        next_cmp_out;
  logic [3:0]  next_ps_cnt;

  always_comb begin
    next_pir = pir;
    if (wr_pir) begin
      next_pir = byte_of(wdata_q, wstrb_q, pir) & `ECC_IRQ_MASK;
    end
    // A set in the clearing cycle wins; events only ever set the unit flag, software writes can set the other unmasked bits.
    if (flag_evt) begin
      next_pir[`ECC_FLAG_BIT] = 1'b1;
    end
  end

  always_comb begin
    next_ccv = ccv;
    if (wr_ccl) begin
      next_ccv[7:0] = byte_of(wdata_q, wstrb_q, ccv[7:0]);
    end
    if (wr_cch) begin
      next_ccv[15:8] = byte_of(wdata_q, wstrb_q, ccv[15:8]);
    end
    // Capture overwrites silently, no overrun mark.
    if (capt_evt) begin
      next_ccv = first_timer_count;
    end
  end

  always_comb begin
    next_cmp_out = cmp_out;
    if (ctrl.mode == `ECC_M_OFF) begin
      next_cmp_out = 1'b0;
    end else if (match_evt) begin
      case (ctrl.mode)
        `ECC_M_TOG: begin
          next_cmp_out = !cmp_out;
        end
        `ECC_M_SET: begin
          next_cmp_out = 1'b1;
        end
        `ECC_M_CLR: begin
          next_cmp_out = 1'b0;
        end
        default: begin
          next_cmp_out = cmp_out;
        end
      endcase
    end
  end

  always_comb begin
    next_ps_cnt = ps_cnt;
    if (!is_capt) begin
      next_ps_cnt = 4'h0;
    end else if (rise) begin
      next_ps_cnt = ps_cnt + 4'h1;
    end
  end

  // ****************************************************************
  // Output steering
  // ****************************************************************

  ecc_pkg::ecc_pins_s next_out;
  ecc_pkg::ecc_pins_s next_oe;

  always_comb begin
    next_out = '0;
    next_oe  = '0;
    if (!is_pwm) begin
      // Steering field ignored; A is the compare pin, the rest port pins.
      next_out.a = cmp_out;
      next_oe.a  = is_cmp && ctrl.mode != `ECC_M_SWI &&
                   ctrl.mode != `ECC_M_SPEC;
    end else begin
      case (ctrl.steer)
        `ECC_ST_SINGLE: begin
          next_out.a = pwm_a_in ^ inv_ac;
          next_oe.a  = 1'b1;
        end
        `ECC_ST_FWD: begin
          next_out.a = !inv_ac;
          next_out.b = inv_bd;
          next_out.c = inv_ac;
          next_out.d = pwm_a_in ^ inv_bd;
          next_oe    = 4'hF;
        end
        `ECC_ST_HALF: begin
          next_out.a = pwm_a_in ^ inv_ac;
          next_out.b = pwm_b_in ^ inv_bd;
          next_oe.a  = 1'b1;
          next_oe.b  = 1'b1;
        end
        default: begin
          next_out.a = inv_ac;
          next_out.b = pwm_a_in ^ inv_bd;
          next_out.c = !inv_ac;
          next_out.d = inv_bd;
          next_oe    = 4'hF;
        end
      endcase
    end
  end

  // ****************************************************************
  // Unit state
  // ****************************************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= `ECC_CTRL_RST;
      pie      <= `ECC_PIE_RST;
      pir      <= `ECC_PIR_RST;
      ccv      <= 16'h0000;
      cmp_out  <= 1'b0;
      ps_cnt   <= 4'h0;
      match_q  <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= byte_of(wdata_q, wstrb_q, ctrl);
      end
      if (wr_pie) begin
        pie <= byte_of(wdata_q, wstrb_q, pie) & `ECC_IRQ_MASK;
      end
      pir     <= next_pir;
      ccv     <= next_ccv;
      cmp_out <= next_cmp_out;
      ps_cnt  <= next_ps_cnt;
      match_q <= match_now;
    end
  end

  // Two-stage synchroniser; only the second stage is looked at.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1    <= 1'b0;
      sync2    <= 1'b0;
      pin_prev <= 1'b0;
    end else if (ce) begin
      sync1    <= capture_pin_in;
      sync2    <= sync1;
      pin_prev <= sync2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      use_second_timer  <= 1'b0;
      duty_value        <= 10'h000;
      first_timer_reset <= 1'b0;
      adc_start         <= 1'b0;
      pin_out           <= '0;
      pin_oe            <= '0;
    end else if (ce) begin
      use_second_timer  <= is_pwm;
      duty_value        <= is_pwm ? {ccv[7:0], ctrl.duty_lo} : 10'h000;
      first_timer_reset <= spec_evt;
      adc_start         <= spec_evt && adc_enabled;
      pin_out           <= next_out;
      pin_oe            <= next_oe;
    end
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= `ECC_RESP_OK;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_got    <= 1'b1;
        awaddr_q  <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_got    <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_hit ? `ECC_RESP_OK : `ECC_RESP_ERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        aw_got    <= 1'b0;
        w_got     <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h00000000;
      s_rresp   <= `ECC_RESP_OK;
    end else if (ce) begin
      if (ar_hs) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rdata   <= rd_word;
        s_rresp   <= rd_hit ? `ECC_RESP_OK : `ECC_RESP_ERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid  <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  timebase_sel_a: assert property (ce |=> use_second_timer == $past(is_pwm))
    else $error("timebase select does not follow mode");

  port_pins_a: assert property (ce && !is_pwm |=> !pin_oe.b && !pin_oe.c && !pin_oe.d)
    else $error("outputs B-D driven outside PWM");

  fwd_bridge_a: assert property (ce && is_pwm && ctrl.steer == `ECC_ST_FWD |=>
                                 pin_out.a == !$past(inv_ac) && pin_out.b == $past(inv_bd))
    else $error("forward bridge static levels wrong");

  toggle_out_a: assert property (ce && match_evt && ctrl.mode == `ECC_M_TOG |=>
                                 cmp_out != $past(cmp_out))
    else $error("compare toggle missing");

  set_out_a: assert property (ce && match_evt && ctrl.mode == `ECC_M_SET |=> cmp_out)
    else $error("compare set missing");

  swi_pin_a: assert property (ce && ctrl.mode == `ECC_M_SWI |=> !pin_oe.a)
    else $error("pin driven in soft interrupt mode");

  spec_event_a: assert property (ce && spec_evt |=> first_timer_reset &&
                                 adc_start == $past(adc_enabled) ##1 !first_timer_reset || !ce)
    else $error("special event pulse wrong");

  capt_copy_a: assert property (ce && capt_evt |=> ccv == $past(first_timer_count) &&
                                pir[`ECC_FLAG_BIT])
    else $error("capture copy or flag missing");

  flag_hold_a: assert property (ce && pir[`ECC_FLAG_BIT] && !wr_pir |=>
                                pir[`ECC_FLAG_BIT])
    else $error("flag cleared without software");

  prescale_clr_a: assert property (ce && !is_capt |=> ps_cnt == 4'h0)
    else $error("prescaler not cleared");

  zero_latch_a: assert property (ce && ctrl.mode == `ECC_M_OFF |=> !cmp_out)
    else $error("compare latch not low when off");

  capt16_c: cover property (ce && capt_evt && ctrl.mode == `ECC_M_C16);
  spec_c: cover property (ce && spec_evt && adc_enabled);
  half_c: cover property (ce && is_pwm && ctrl.steer == `ECC_ST_HALF ##1 pin_oe.b);
  write_c: cover property (s_bvalid && s_bready && s_bresp == `ECC_RESP_OK);

endmodule
`default_nettype wire

/* File: testbench/ecc_far_side.sv */
// Far-side model: edge source sharing the capture pin with the unit's own driver.
`timescale 1ns/1ps
`default_nettype none

module ecc_far_side (
  input  wire logic               src_level,
  input  wire ecc_pkg::ecc_pins_s pin_out,
  input  wire ecc_pkg::ecc_pins_s pin_oe,
  output logic                    pin_level
);
  // The source sets the level only while the pin is an input; once the unit drives the pin,
  // the unit's own level is what the edge detector sees.
  assign pin_level = pin_oe.a ? pin_out.a : src_level;
endmodule

`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the capture/compare/PWM unit.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_regs.svh"

module tb;
  logic               aclk, aresetn, ce, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic               s_awready, s_wready, s_bvalid, s_arready, s_rvalid, src_level;
  logic               capture_pin_in, pwm_a_in, pwm_b_in, adc_enabled, use_second_timer;
  logic               first_timer_reset, adc_start;
  logic [7:0]         s_awaddr, s_araddr;
  logic [31:0]        s_wdata, s_rdata, rd_data;
  logic [3:0]         s_wstrb;
  logic [1:0]         s_bresp, s_rresp, rs, rr;
  logic [15:0]        first_timer_count;
  logic [9:0]         duty_value;
  ecc_pkg::ecc_pins_s pin_out, pin_oe;
  int                 mismatches = 0;
  int                 checked = 0;
  int                 n_rst = 0;
  int                 n_adc = 0;

  ecc_unit DUT (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .capture_pin_in, .first_timer_count, .pwm_a_in,
    .pwm_b_in, .adc_enabled, .use_second_timer, .duty_value, .first_timer_reset, .adc_start,
    .pin_out, .pin_oe);

  ecc_far_side far (.src_level, .pin_out, .pin_oe, .pin_level(capture_pin_in));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (first_timer_reset === 1'b1) n_rst <= n_rst + 1;
    if (adc_start === 1'b1) n_adc <= n_adc + 1;
  end

  // ************************************************************
  // Bus and compare helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= {24'h000000, d};
    s_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        aw = 1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w = 1;
        s_wvalid <= 1'b0;
      end
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    rd_data = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic pulse_pin(input int n);
    repeat (n) begin
      src_level <= 1'b1;
      cyc(3);
      src_level <= 1'b0;
      cyc(3);
    end
  endtask

  // Checks the captured pair and the flag, then clears the flag.
  task automatic exp_cap(input logic [15:0] v);
    rd(`ECC_OFF_CCL);
    chk(rd_data, {24'h000000, v[7:0]});
    rd(`ECC_OFF_CCH);
    chk(rd_data, {24'h000000, v[15:8]});
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000020);
    wr(`ECC_OFF_PIR, 8'h00);
  endtask

  // One match window on the timer, then the flag is checked and cleared.
  task automatic hit();
    first_timer_count <= 16'h1234;
    cyc(4);
    first_timer_count <= 16'h0000;
    cyc(3);
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000020);
    wr(`ECC_OFF_PIR, 8'h00);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    rd(`ECC_OFF_CTRL);
    chk(rd_data, 32'h00000000);
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000000);
    wr(`ECC_OFF_PIE, 8'hFF);
    rd(`ECC_OFF_PIE);
    chk(rd_data, {24'h000000, `ECC_IRQ_MASK});
    wr(8'h20, 8'h55);
    chk({30'h0, rs}, {30'h0, `ECC_RESP_ERR});
    rd(8'h20);
    chk({30'h0, rr}, {30'h0, `ECC_RESP_ERR});
    wr(`ECC_OFF_PIE, 8'h00);
  endtask

  task automatic t_capture();
    first_timer_count <= 16'hA5C3;
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_CRISE});
    pulse_pin(1);
    exp_cap(16'hA5C3);
    first_timer_count <= 16'h5A3C;
    pulse_pin(1);
    first_timer_count <= 16'h7E81;
    pulse_pin(1);
    exp_cap(16'h7E81);
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000000);
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_CFALL});
    first_timer_count <= 16'h1111;
    src_level <= 1'b1;
    cyc(6);
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000000);
    first_timer_count <= 16'h2222;
    src_level <= 1'b0;
    cyc(6);
    exp_cap(16'h2222);
  endtask

  task automatic t_prescale(input logic [3:0] m, input int n, input logic [15:0] v);
    wr(`ECC_OFF_CTRL, {4'h0, m});
    pulse_pin(2);
    wr(`ECC_OFF_CTRL, 8'h00);
    wr(`ECC_OFF_PIR, 8'h00);
    wr(`ECC_OFF_CTRL, {4'h0, m});
    first_timer_count <= v;
    pulse_pin(n - 1);
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000000);
    pulse_pin(1);
    exp_cap(v);
  endtask

  task automatic t_compare();
    wr(`ECC_OFF_CTRL, 8'h00);
    first_timer_count <= 16'h0000;
    wr(`ECC_OFF_CCL, 8'h34);
    wr(`ECC_OFF_CCH, 8'h12);
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_SET});
    hit();
    chk({31'h0, pin_out.a}, 32'h1);
    chk({28'h0, pin_oe & 4'h7}, 32'h0);
    chk({21'h0, use_second_timer, duty_value}, 32'h0);
    wr(`ECC_OFF_CTRL, 8'h00);
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_TOG});
    cyc(3);
    chk({31'h0, pin_out.a}, 32'h0);
    hit();
    chk({31'h0, pin_out.a}, 32'h1);
    hit();
    chk({31'h0, pin_out.a}, 32'h0);
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_SET});
    hit();
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_CLR});
    hit();
    chk({31'h0, pin_out.a}, 32'h0);
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_SWI});
    hit();
    chk({31'h0, pin_oe.a}, 32'h0);
    adc_enabled <= 1'b1;
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_SPEC});
    hit();
    chk(n_rst, 1);
    chk(n_adc, 1);
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000000);
    adc_enabled <= 1'b0;
    hit();
    chk(n_rst, 2);
    chk(n_adc, 1);
  endtask

  // Clock enable low hides pin edges, then a mid-run reset clears the control byte.
  task automatic t_freeze();
    wr(`ECC_OFF_CTRL, {4'h0, `ECC_M_CRISE});
    ce <= 1'b0;
    cyc(1);
    pulse_pin(2);
    ce <= 1'b1;
    cyc(4);
    rd(`ECC_OFF_PIR);
    chk(rd_data, 32'h00000000);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
    rd(`ECC_OFF_CTRL);
    chk(rd_data, 32'h00000000);
  endtask

  // Only defined mode codes are ever written; the reserved ones stay unused.
  task automatic t_pwm();
    logic [3:0] eo, eoe, mm;
    logic [1:0] ss;
    logic       a;
    wr(`ECC_OFF_CTRL, 8'h00);
    wr(`ECC_OFF_CCL, 8'hB7);
    for (int m = 12; m < 16; m++) begin
      for (int s = 0; s < 4; s++) begin
        for (int k = 0; k < 2; k++) begin
          mm = m[3:0];
          ss = s[1:0];
          a = k[0];
          pwm_a_in <= a;
          pwm_b_in <= ~a;
          wr(`ECC_OFF_CTRL, {ss, 2'b10, mm});
          cyc(3);
          case (ss)
            `ECC_ST_SINGLE: begin eo = {a, 3'b000}; eoe = 4'b1000; end
            `ECC_ST_FWD:    begin eo = {3'b100, a}; eoe = 4'b1111; end
            `ECC_ST_HALF:   begin eo = {a, ~a, 2'b00}; eoe = 4'b1100; end
            default:        begin eo = {1'b0, a, 2'b10}; eoe = 4'b1111; end
          endcase
          eo = eo ^ {mm[1], mm[0], mm[1], mm[0]};
          chk({28'h0, pin_oe}, {28'h0, eoe});
          chk({28'h0, pin_out & eoe}, {28'h0, eo & eoe});
          chk({21'h0, use_second_timer, duty_value}, 32'h000006DE);
        end
      end
    end
    wr(`ECC_OFF_CTRL, 8'h00);
    cyc(3);
    chk({27'h0, use_second_timer, pin_oe}, 32'h0);
  endtask

  task automatic end_sim();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    end_sim();
  end

  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, src_level} = '0;
    {pwm_a_in, pwm_b_in, adc_enabled, s_awaddr, s_araddr, s_wdata} = '0;
    first_timer_count = 16'h0000;
    s_wstrb = 4'hF;
    ce = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_capture();
    t_prescale(`ECC_M_C4, 4, 16'h0F0F);
    t_prescale(`ECC_M_C16, 16, 16'hF00D);
    t_compare();
    t_freeze();
    t_pwm();
    end_sim();
  end
endmodule

`default_nettype wire
